// file: hw/maint_pkg.sv
/*
  Constants for the maintenance-mode controller: register offsets, encodings,
  status bit positions, timing and analog hold levels.
  Assumes a 100 MHz system clock.
*/
package maint_pkg;
  localparam logic [15:0] HOST_SERVICE_CONTROL_ADDR = 16'h9c72;
  localparam logic [15:0] UNIT_CONDITION_WORD_ADDR = 16'h9e44;
  localparam logic [15:0] HOST_OFF = 16'h0000;
  localparam logic [15:0] HOST_ON_HOLD = 16'h0001;
  localparam logic [15:0] HOST_ON_TIMED = 16'h0011;
  localparam logic [15:0] HOST_RESET_VALUE = 16'h0000;
  // status byte 1 (high byte of the word)
  localparam int SB1_LOW_FLOW_1 = 5;
  localparam int SB1_LOW_FLOW_2 = 4;
  localparam int SB1_PYRO_BROKEN = 3;
  localparam int SB1_SENSOR_FAULT = 2;
  localparam int SB1_ALARM_FIRST = 1;
  localparam int SB1_ALARM_SECOND = 0;
  // status byte 2 (low byte of the word)
  localparam int SB2_SERVICE_FIRST = 0;
  localparam int SB2_SERVICE_SECOND = 1;
  localparam int SB2_TEST_MODE = 2;
  localparam int SB2_HOST_SERVICE = 4;
  localparam longint CLOCK_HZ = 100_000_000;
  localparam longint SELF_CLEAR_S = 600;
  localparam logic [35:0] SELF_CLEAR_CYCLES = 36'(SELF_CLEAR_S * CLOCK_HZ);
  // analog hold levels in microamps
  localparam logic [15:0] AOUT_HOLD_UA = 16'h0fa0;
  localparam logic [15:0] AOUT_HOLD_OXY_UA = 16'h43f8;
  localparam logic [3:0] RANGE_DIV_DIGIT = 4'h9;
  localparam int RANGE_VALUE_W = 17;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_FIRST, MODE_SECOND} sel_mode_t;
endpackage

// file: hw/range_if.sv
/*
  Carrier between the controller and its range-code decoder.
  Assumes maint_pkg is compiled first.
*/
interface range_if;
  logic [11:0] code;
  logic [maint_pkg::RANGE_VALUE_W-1:0] value_x10;
  logic valid;
  modport decoder (input code, output value_x10, output valid);
  modport user (output code, input value_x10, input valid);
endinterface

// file: hw/range_decoder.sv
/*
  Decodes a three-digit BCD range code into the range value times ten.
  Assumes a code from logic on the same clock; result is one cycle later.
*/
module range_decoder
  import maint_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  range_if.decoder rng
);
  import maint_pkg::*;

  logic [RANGE_VALUE_W-1:0] value_d, value_q;
  logic valid_d, valid_q;
  logic [RANGE_VALUE_W-1:0] sig;

  always_comb begin
    sig = RANGE_VALUE_W'(rng.code[11:8]) * RANGE_VALUE_W'(10)
        + RANGE_VALUE_W'(rng.code[7:4]);
    valid_d = (rng.code[11:8] < 4'ha) && (rng.code[7:4] < 4'ha);
    // [R13] digit scale
    case (rng.code[3:0])
      4'h0: value_d = RANGE_VALUE_W'(sig * RANGE_VALUE_W'(10));
      4'h1: value_d = RANGE_VALUE_W'(sig * RANGE_VALUE_W'(100));
      4'h2: value_d = RANGE_VALUE_W'(sig * RANGE_VALUE_W'(1000));
      RANGE_DIV_DIGIT: value_d = sig;
      default: begin
        value_d = '0;
        valid_d = 1'b0;
      end
    endcase
    // illegal significant digits report zero, not a bogus product
    if (!valid_d) begin
      value_d = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= '0;
      valid_q <= 1'b0;
    end else begin
      value_q <= value_d;
      valid_q <= valid_d;
    end
  end

  assign rng.value_x10 = value_q;
  assign rng.valid = valid_q;
endmodule

// file: hw/maintenance_mode_control.sv
/*
  Maintenance-mode controller: switch and host service modes, self-clearing
  timer, status word, alarm output forcing, analog hold and display flags.
  Assumes register requests come from on-chip framing logic on this clock;
  switch pins are asynchronous and synchronised here.
*/
// What this block does
// [R1] switch picks first or second service
// [R2] master writes host register on/off
// [R3] 0000 off, 0001 on, 0011 timed
// [R4] timed host service ends after ten minutes
// [R5] host service acts like first mode
// [R6] status word: byte1 high, byte2 low
// [R7] byte2 bits 0,1,4 show modes
// [R8] service forces contacts off, trouble on
// [R9] alarm status still reported during service
// [R10] power off in service raises trouble
// [R11] second mode holds analog output level
// [R12] display shows first/second mode indicator
// [R13] range code: two digits, scale digit
// [R14] byte1 bits 5..2 carry fault flags
// [R15] modes independent; off cancels timer
module maintenance_mode_control
  import maint_pkg::*;
#(
  parameter logic [35:0] SELF_CLEAR_COUNT = SELF_CLEAR_CYCLES
)(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sel_first_pin,
  input wire logic sel_second_pin,
  input wire logic power_off_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic [1:0] gas_alarm_req,
  input wire logic trouble_req,
  input wire logic [3:0] fault_flags,
  input wire logic test_mode,
  input wire logic oxygen_sensor,
  output logic [1:0] gas_contact,
  output logic trouble_oc_o,
  output logic trouble_oc_oe_n,
  output logic trouble_raise,
  output logic aout_hold,
  output logic [15:0] aout_hold_ua,
  output logic disp_first,
  output logic disp_second,
  input wire logic [11:0] range_code,
  output logic [maint_pkg::RANGE_VALUE_W-1:0] range_value_x10,
  output logic range_valid
);
  import maint_pkg::*;

  // the expiry compare subtracts one, so a zero count cannot be served
  if (SELF_CLEAR_COUNT == 36'h0_0000_0000) begin : g_count_check
    $error("SELF_CLEAR_COUNT must be at least one");
  end

  // pin synchronisers; stage one feeds only stage two
  logic [2:0] sync1_q, sync2_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {power_off_pin, sel_second_pin, sel_first_pin};
      sync2_q <= sync1_q;
    end
  end

  sel_mode_t sel_mode;
  always_comb begin
    // [R1] switch decode
    case (sync2_q[1:0])
      2'b01: sel_mode = MODE_FIRST;
      2'b10: sel_mode = MODE_SECOND;
      // both contacts closed is a broken switch; favour the first mode
      2'b11: sel_mode = MODE_FIRST;
      default: sel_mode = MODE_NORMAL;
    endcase
  end

  // host service register and self-clear timer
  logic [15:0] host_reg_d, host_reg_q;
  logic host_on_d, host_on_q;
  logic timed_d, timed_q;
  logic [35:0] cnt_d, cnt_q;
  logic host_write;
  assign host_write = reg_wr && (reg_addr == HOST_SERVICE_CONTROL_ADDR);

  always_comb begin
    host_reg_d = host_reg_q;
    host_on_d = host_on_q;
    timed_d = timed_q;
    cnt_d = cnt_q;
    if (timed_q) begin
      cnt_d = cnt_q + 36'h0_0000_0001;
      // [R4] ten minute expiry
      if (cnt_q >= SELF_CLEAR_COUNT - 36'h0_0000_0001) begin
        host_on_d = 1'b0;
        timed_d = 1'b0;
        host_reg_d = HOST_OFF;
        cnt_d = '0;
      end
    end
    // [R2] master write
    if (host_write) begin
      // [R3] value encoding; other values keep host_reg_q, even over a same-cycle expiry clear
      case (reg_wdata)
        HOST_OFF: begin
          // [R15] immediate off
          host_reg_d = HOST_OFF;
          host_on_d = 1'b0;
          timed_d = 1'b0;
          cnt_d = '0;
        end
        HOST_ON_HOLD: begin
          host_reg_d = HOST_ON_HOLD;
          host_on_d = 1'b1;
          timed_d = 1'b0;
          cnt_d = '0;
        end
        HOST_ON_TIMED: begin
          // a repeat write restarts the full interval
          host_reg_d = HOST_ON_TIMED;
          host_on_d = 1'b1;
          timed_d = 1'b1;
          cnt_d = '0;
        end
        default: host_reg_d = host_reg_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      host_reg_q <= HOST_RESET_VALUE;
      host_on_q <= 1'b0;
      timed_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      host_reg_q <= host_reg_d;
      host_on_q <= host_on_d;
      timed_q <= timed_d;
      cnt_q <= cnt_d;
    end
  end

  // mode flags and forced outputs
  logic svc_first, svc_second, svc_any;
  logic [15:0] status_word;
  logic [1:0] contact_d, contact_q;
  logic oc_on_d, oc_on_q, raise_d, raise_q, hold_d, hold_q;
  logic [15:0] hold_ua_d, hold_ua_q;
  logic disp1_d, disp1_q, disp2_d, disp2_q;

  always_comb begin
    // [R15] each flag from its own source
    svc_first = (sel_mode == MODE_FIRST);
    svc_second = (sel_mode == MODE_SECOND);
    svc_any = svc_first || svc_second || host_on_q;
    status_word = 16'h0000;
    // [R6] byte order
    // [R14] fault flags
    status_word[8 + SB1_LOW_FLOW_1] = fault_flags[3];
    status_word[8 + SB1_LOW_FLOW_2] = fault_flags[2];
    status_word[8 + SB1_PYRO_BROKEN] = fault_flags[1];
    status_word[8 + SB1_SENSOR_FAULT] = fault_flags[0];
    // [R9] alarms still reported
    status_word[8 + SB1_ALARM_FIRST] = gas_alarm_req[0];
    status_word[8 + SB1_ALARM_SECOND] = gas_alarm_req[1];
    // [R7] mode bits
    status_word[SB2_SERVICE_FIRST] = svc_first;
    status_word[SB2_SERVICE_SECOND] = svc_second;
    status_word[SB2_TEST_MODE] = test_mode;
    status_word[SB2_HOST_SERVICE] = host_on_q;
    // [R8] force contacts off
    // [R5] host acts as first
    contact_d = svc_any ? 2'b00 : gas_alarm_req;
    // open collector conducts when healthy; service pins it on
    oc_on_d = svc_any ? 1'b1 : !trouble_req;
    // [R10] power off in service
    raise_d = svc_any && sync2_q[2];
    // [R11] analog hold
    hold_d = svc_second;
    hold_ua_d = oxygen_sensor ? AOUT_HOLD_OXY_UA : AOUT_HOLD_UA;
    // [R12] display flags
    disp1_d = svc_first || host_on_q;
    disp2_d = svc_second;
  end

  // register read answer, one cycle after the request
  logic [15:0] rdata_d, rdata_q;
  logic ack_d, ack_q;
  always_comb begin
    ack_d = reg_rd || reg_wr;
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        HOST_SERVICE_CONTROL_ADDR: rdata_d = host_reg_q;
        UNIT_CONDITION_WORD_ADDR: rdata_d = status_word;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      contact_q <= 2'b00;
      oc_on_q <= 1'b1;
      raise_q <= 1'b0;
      hold_q <= 1'b0;
      hold_ua_q <= AOUT_HOLD_UA;
      disp1_q <= 1'b0;
      disp2_q <= 1'b0;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      contact_q <= contact_d;
      oc_on_q <= oc_on_d;
      raise_q <= raise_d;
      hold_q <= hold_d;
      hold_ua_q <= hold_ua_d;
      disp1_q <= disp1_d;
      disp2_q <= disp2_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign gas_contact = contact_q;
  assign trouble_oc_o = 1'b0;
  assign trouble_oc_oe_n = !oc_on_q;
  assign trouble_raise = raise_q;
  assign aout_hold = hold_q;
  assign aout_hold_ua = hold_ua_q;
  assign disp_first = disp1_q;
  assign disp_second = disp2_q;
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;

  range_if rng ();
  assign rng.code = range_code;
  range_decoder u_range (
    .clock(clock),
    .arst_n(arst_n),
    .rng(rng.decoder)
  );
  assign range_value_x10 = rng.value_x10;
  assign range_valid = rng.valid;
endmodule

// file: test/maintenance_mode_control_monitor.sv
/*
  Port checker for the maintenance-mode controller.
  Assumes it is bound to maintenance_mode_control and sees only its ports.
*/
module maintenance_mode_control_monitor (
  input logic clock,
  input logic arst_n,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic reg_ack,
  input logic oxygen_sensor,
  input logic [1:0] gas_contact,
  input logic trouble_oc_o,
  input logic trouble_oc_oe_n,
  input logic trouble_raise,
  input logic aout_hold,
  input logic [15:0] aout_hold_ua,
  input logic disp_first,
  input logic disp_second,
  input logic [11:0] range_code,
  input logic [maint_pkg::RANGE_VALUE_W-1:0] range_value_x10,
  input logic range_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  import maint_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_ack_follows_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("ack without request");
  a_rdata_idle_zero: assert property (!reg_ack |-> reg_rdata == 16'h0000)
    else $error("read data outside ack");
  a_service_forcing: assert property ((disp_first || disp_second) |->
    gas_contact == 2'b00 && !trouble_oc_oe_n)
    else $error("outputs not forced in service");
  a_collector_low: assert property (trouble_oc_o == 1'b0)
    else $error("collector drive not low");
  a_hold_with_second: assert property (aout_hold == disp_second)
    else $error("analog hold differs from second mode");
  // hold level is registered, so it follows the sensor select one cycle late
  a_hold_level: assert property (aout_hold |->
    aout_hold_ua == ($past(oxygen_sensor) ? AOUT_HOLD_OXY_UA : AOUT_HOLD_UA))
    else $error("wrong analog hold level");
  a_raise_in_service: assert property (trouble_raise |-> (disp_first || disp_second))
    else $error("trouble raised outside service");
  a_range_next_cycle: assert property (range_code == 12'h159 |=>
    range_value_x10 == 17'h0_000f && range_valid)
    else $error("range decode wrong");
  c_host_seen: cover property (reg_ack && reg_rdata[SB2_HOST_SERVICE]);
  c_raise_seen: cover property (trouble_raise);
  c_hold_seen: cover property (aout_hold);
endmodule

// file: test/modbus_master_model.sv
/*
  Register master model: one request at a time on the strobe port.
  Assumes the controller acks exactly one cycle after taking a request.
*/
module modbus_master_model (
  input logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic reg_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(posedge clock);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    // released lines show inverse, not stale values
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    ok = (reg_ack === 1'b1);
  endtask
endmodule

// file: test/maintenance_mode_control_bench.sv
/*
  Self-checking bench for the maintenance-mode controller.
  Assumes the master model and monitor files are compiled before this one.
*/
module maintenance_mode_control_bench import maint_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, arst_n, sel_first_pin, sel_second_pin, power_off_pin, trouble_req;
  logic test_mode, oxygen_sensor, reg_wr, reg_rd, reg_ack, trouble_oc_o, trouble_oc_oe_n;
  logic trouble_raise, aout_hold, disp_first, disp_second, range_valid, ok;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, aout_hold_ua, q;
  logic [1:0] gas_alarm_req, gas_contact;
  logic [3:0] fault_flags;
  logic [11:0] range_code;
  logic [RANGE_VALUE_W-1:0] range_value_x10;
  int err_count = 0;
  int checks_done = 0;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // short self-clear count keeps the run brief
  localparam int SELF_CLEAR_SIM = 50;
  maintenance_mode_control #(.SELF_CLEAR_COUNT(36'(SELF_CLEAR_SIM))) dut_u (.clock, .arst_n,
    .sel_first_pin, .sel_second_pin, .power_off_pin, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_ack, .gas_alarm_req, .trouble_req, .fault_flags,
    .test_mode, .oxygen_sensor, .gas_contact, .trouble_oc_o, .trouble_oc_oe_n,
    .trouble_raise, .aout_hold, .aout_hold_ua, .disp_first, .disp_second, .range_code,
    .range_value_x10, .range_valid);
  modbus_master_model bm (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    bm.access(w, a, d, q, ok);
    check(ok, 1'b1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_host;
    logic [15:0] codes [3] = '{HOST_ON_HOLD, HOST_ON_TIMED, HOST_OFF};
    gas_alarm_req = 2'b11;
    foreach (codes[i]) begin
      acc(1, HOST_SERVICE_CONTROL_ADDR, codes[i]);
      acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
      check(q, codes[i]);
      acc(0, UNIT_CONDITION_WORD_ADDR, 16'h0000);
      check(q, {8'h03, 3'b000, codes[i] != 16'h0000, 4'h0});
      check(gas_contact, (codes[i] != 16'h0000) ? 2'b00 : 2'b11);
      check(disp_first, codes[i] != 16'h0000);
    end
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_ON_HOLD);
    acc(1, HOST_SERVICE_CONTROL_ADDR, 16'h0002);
    acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
    check(q, HOST_ON_HOLD);
    acc(0, 16'h0000, 16'h0000);
    check(q, 16'h0000);
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_OFF);
    // a write to the status word must not reach the host register
    acc(1, UNIT_CONDITION_WORD_ADDR, HOST_ON_HOLD);
    acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
    check(q, HOST_OFF);
    $display("host codes test done");
  endtask
  task automatic t_timer;
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_ON_TIMED);
    // read taken on the expiry edge still sees the mode on
    cyc(SELF_CLEAR_SIM - 2);
    acc(0, UNIT_CONDITION_WORD_ADDR, 16'h0000);
    check(q[SB2_HOST_SERVICE], 1'b1);
    check(disp_first, 1'b1);
    cyc(1);
    check(disp_first, 1'b0);
    acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
    check(q, HOST_OFF);
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_ON_TIMED);
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_ON_HOLD);
    cyc(60);
    acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
    check(q, HOST_ON_HOLD);
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_OFF);
    acc(0, UNIT_CONDITION_WORD_ADDR, 16'h0000);
    check(q, 16'h0300);
    $display("timer test done");
  endtask
  task automatic t_switch;
    fault_flags = 4'hf;
    test_mode = 1'b1;
    trouble_req = 1'b1;
    cyc(3);
    check(trouble_oc_oe_n, 1'b1);
    sel_first_pin = 1'b1;
    cyc(4);
    check({gas_contact, trouble_oc_oe_n, disp_first}, 4'b0001);
    acc(0, UNIT_CONDITION_WORD_ADDR, 16'h0000);
    check(q, 16'h3f05);
    check(trouble_raise, 1'b0);
    power_off_pin = 1'b1;
    cyc(4);
    check(trouble_raise, 1'b1);
    power_off_pin = 1'b0;
    sel_first_pin = 1'b0;
    sel_second_pin = 1'b1;
    cyc(4);
    check({aout_hold, disp_second, disp_first, aout_hold_ua}, {3'b110, 16'h0fa0});
    acc(0, UNIT_CONDITION_WORD_ADDR, 16'h0000);
    check(q, 16'h3f06);
    oxygen_sensor = 1'b1;
    cyc(2);
    check(aout_hold_ua, 16'h43f8);
    // both contacts closed falls back to the first mode
    sel_first_pin = 1'b1;
    cyc(4);
    check({disp_first, disp_second, aout_hold}, 3'b100);
    sel_first_pin = 1'b0;
    sel_second_pin = 1'b0;
    cyc(4);
    check({gas_contact, aout_hold}, 3'b110);
    $display("switch test done");
  endtask
  task automatic t_range;
    logic [11:0] codes [7] = '{12'h010, 12'h159, 12'h102, 12'h079, 12'h902, 12'h123,
                               12'h0a0};
    logic [16:0] vals [7] = '{17'h0_000a, 17'h0_000f, 17'h0_2710, 17'h0_0007, 17'h1_5f90,
                              17'h0_0000, 17'h0_0000};
    foreach (codes[i]) begin
      range_code = codes[i];
      cyc(2);
      check({range_valid, range_value_x10}, {i < 5, vals[i]});
    end
    $display("range test done");
  endtask
  task automatic t_reset;
    acc(1, HOST_SERVICE_CONTROL_ADDR, HOST_ON_HOLD);
    cyc(2);
    // reset acts at once, without waiting for a clock edge
    arst_n = 1'b0;
    #1;
    check({disp_first, reg_ack}, 2'b00);
    cyc(2);
    arst_n = 1'b1;
    acc(0, HOST_SERVICE_CONTROL_ADDR, 16'h0000);
    check(q, HOST_OFF);
    check(disp_first, 1'b0);
    $display("reset test done");
  endtask
  initial begin
    {arst_n, sel_first_pin, sel_second_pin, power_off_pin, trouble_req} = 5'h00;
    {test_mode, oxygen_sensor, gas_alarm_req, fault_flags} = 8'h00;
    range_code = 12'h000;
    repeat (4) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check({gas_contact, trouble_oc_oe_n, aout_hold_ua}, {3'b000, 16'h0fa0});
    t_host;
    t_timer;
    t_switch;
    t_range;
    t_reset;
    stop_test;
  end
  initial begin
    #100us;
    err_count++;
    stop_test;
  end
endmodule
bind maintenance_mode_control maintenance_mode_control_monitor mon_u (.clock, .arst_n,
  .reg_wr, .reg_rd, .reg_rdata, .reg_ack, .oxygen_sensor, .gas_contact, .trouble_oc_o,
  .trouble_oc_oe_n, .trouble_raise, .aout_hold, .aout_hold_ua, .disp_first, .disp_second,
  .range_code, .range_value_x10, .range_valid);
